// File: rtl/bfm_bidir_fifo.v
// bfm_bidir_fifo.v: two opposite fifos, two mailboxes and their flags
// assumes: port clocks and controls are pins, slower than mclk by far
//
// Functional notes
// R1: a b read of a full a2b queue raises porta_input_ready next a cycle.
// R2: porta_full_n releases on the next a cycle after a b read frees space.
// R3: narrow b sizes free a2b space only on the last piece of a long word.
// R4: an a read of a full b2a queue raises portb_input_ready next b cycle.
// R5: narrow b writes drop portb_input_ready only on the completing piece.
// R6: portb_full_n releases next b cycle; asserts only on completing piece.
// R7: a writes above threshold release portb_almost_empty_n next b cycle.
// R8: narrow b reads assert portb_almost_empty_n only on the last piece.
// R9: b writes above threshold release porta_almost_empty_n next a cycle.
// R10: b reads below threshold release porta_almost_full_n next a cycle.
// R11: narrow b writes assert portb_almost_full_n only on the last piece.
// R12: almost-full levels are taken against the queue depth.
// R13: a writes a2b with select low, dir low, mail low, enable high.
// R14: b reads a2b with select low, dir high, mail low, enable high.
// R15: b writes b2a with select low, dir low, mail low, enable high.
// R16: word size: a2b mail keeps a bits 17..0, shown on b bits 17..0.
// R17: byte size: a2b mail keeps a bits 8..0, shown on b bits 8..0.
// R18: word size: b2a mail keeps b bits 17..0, shown on a bits 17..0.
// R19: byte size: b2a mail keeps b bits 8..0, shown on a bits 8..0.
// R20: a reads b2a with select low, dir high, mail low, enable high.
// R21: mail full flag lowers on its write, rises on the far port read.
// R22: flags moved by the far port pass two stages into their own port.
`include "bfm_defines.vh"
`default_nettype none

module bfm_bidir_fifo (
  // clock and reset
  input  wire        mclk,
  input  wire        nrst,
  // port a pins
  input  wire        port_a_clock,
  input  wire        porta_select_n,
  input  wire        porta_dir,
  input  wire        porta_mail_sel,
  input  wire        porta_enable,
  input  wire [35:0] porta_data_in,
  output wire [35:0] porta_data_out,
  output wire        porta_data_oe_n,
  // port a flags
  output wire        porta_full_n,
  output wire        porta_input_ready,
  output wire        porta_almost_full_n,
  output wire        porta_almost_empty_n,
  output wire        a2b_mail_full_n,
  // port b pins
  input  wire        port_b_clock,
  input  wire        portb_select_n,
  input  wire        portb_dir,
  input  wire        portb_mail_sel,
  input  wire        portb_enable,
  input  wire [1:0]  portb_size,
  input  wire        portb_big_endian,
  input  wire [35:0] portb_data_in,
  output wire [35:0] portb_data_out,
  output wire        portb_data_oe_n,
  // port b flags
  output wire        portb_full_n,
  output wire        portb_input_ready,
  output wire        portb_almost_full_n,
  output wire        portb_almost_empty_n,
  output wire        b2a_mail_full_n
);

  // ----------------------------------------------------------------------
  // pin sampling and port clock edges
  // ----------------------------------------------------------------------
  wire [`BFM_PA_W-1:0] a_raw;
  wire [`BFM_PB_W-1:0] b_raw;
  wire [`BFM_PA_W-1:0] a_s;
  wire [`BFM_PB_W-1:0] b_s;
  reg  [`BFM_PA_W-1:0] a_prev_ff;
  reg  [`BFM_PB_W-1:0] b_prev_ff;

  assign a_raw = {port_a_clock, porta_select_n, porta_dir, porta_mail_sel,
                  porta_enable, porta_data_in};
  assign b_raw = {portb_big_endian, portb_size, port_b_clock, portb_select_n,
                  portb_dir, portb_mail_sel, portb_enable, portb_data_in};

  bfm_sync2 #(.W(`BFM_PA_W)) u_sync_a (
    .mclk (mclk),
    .nrst (nrst),
    .d    (a_raw),
    .q    (a_s)
  );

  bfm_sync2 #(.W(`BFM_PB_W)) u_sync_b (
    .mclk (mclk),
    .nrst (nrst),
    .d    (b_raw),
    .q    (b_s)
  );

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      a_prev_ff <= {`BFM_PA_W{1'b0}};
      b_prev_ff <= {`BFM_PB_W{1'b0}};
    end else begin
      a_prev_ff <= a_s;
      b_prev_ff <= b_s;
    end
  end

  // controls are taken as they stood just before the rising edge
  wire        a_edge  = a_s[`BFM_V_CLK] & ~a_prev_ff[`BFM_V_CLK];
  wire        b_edge  = b_s[`BFM_V_CLK] & ~b_prev_ff[`BFM_V_CLK];
  wire        a_sel   = a_edge & ~a_prev_ff[`BFM_V_SEL_N] & a_prev_ff[`BFM_V_EN];
  wire        b_sel   = b_edge & ~b_prev_ff[`BFM_V_SEL_N] & b_prev_ff[`BFM_V_EN];
  wire        a_dir   = a_prev_ff[`BFM_V_DIR];
  wire        b_dir   = b_prev_ff[`BFM_V_DIR];
  wire        a_mail  = a_prev_ff[`BFM_V_MAIL];
  wire        b_mail  = b_prev_ff[`BFM_V_MAIL];
  wire [35:0] a_data  = a_prev_ff[35:0];
  wire [35:0] b_data  = b_prev_ff[35:0];
  wire [1:0]  b_size  = b_prev_ff[`BFM_V_SIZE_HI:`BFM_V_SIZE_LO];
  wire        b_big   = b_prev_ff[`BFM_V_BIG];

  // ----------------------------------------------------------------------
  // queue pointers, views and levels
  // ----------------------------------------------------------------------
  reg  [8:0] a2b_wptr_ff;
  reg  [8:0] a2b_rptr_ff;
  reg  [8:0] b2a_wptr_ff;
  reg  [8:0] b2a_rptr_ff;
  reg  [8:0] a2b_r_s1_ff;
  reg  [8:0] a2b_rview_a_ff;
  reg  [8:0] b2a_w_s1_ff;
  reg  [8:0] b2a_wview_a_ff;
  reg  [8:0] a2b_w_s1_ff;
  reg  [8:0] a2b_wview_b_ff;
  reg  [8:0] b2a_r_s1_ff;
  reg  [8:0] b2a_rview_b_ff;

  wire [8:0] a2b_cnt_a = a2b_wptr_ff - a2b_rview_a_ff;
  wire [8:0] a2b_cnt_b = a2b_wview_b_ff - a2b_rptr_ff;
  wire [8:0] b2a_cnt_b = b2a_wptr_ff - b2a_rview_b_ff;
  wire [8:0] b2a_cnt_a = b2a_wview_a_ff - b2a_rptr_ff;

  assign porta_full_n         = (a2b_cnt_a != `BFM_DEPTH);                        // R2
  assign porta_input_ready    = (a2b_cnt_a != `BFM_DEPTH);                        // R1
  assign porta_almost_full_n  = (a2b_cnt_a < (`BFM_DEPTH - `BFM_AF_OFFSET));      // R12
  assign porta_almost_empty_n = (b2a_cnt_a > `BFM_AE_OFFSET);                     // R9
  assign portb_full_n         = (b2a_cnt_b != `BFM_DEPTH);                        // R6
  assign portb_input_ready    = (b2a_cnt_b != `BFM_DEPTH);                        // R4
  assign portb_almost_full_n  = (b2a_cnt_b < (`BFM_DEPTH - `BFM_AF_OFFSET));      // R11
  assign portb_almost_empty_n = (a2b_cnt_b > `BFM_AE_OFFSET);                     // R7

  // ----------------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------------
  reg  [1:0] b_rd_idx_ff;
  reg  [1:0] b_wr_idx_ff;
  reg         a2b_mail_full_n_ff;
  reg         b2a_mail_full_n_ff;
  wire [1:0] b_last_idx = (b_size == `BFM_SIZE_WORD) ? `BFM_LAST_WORD :
                          (b_size == `BFM_SIZE_BYTE) ? `BFM_LAST_BYTE : `BFM_IDX_ZERO;
  wire [1:0] b_rd_slot  = b_big ? (b_last_idx - b_rd_idx_ff) : b_rd_idx_ff;
  wire [1:0] b_wr_slot  = b_big ? (b_last_idx - b_wr_idx_ff) : b_wr_idx_ff;
  wire       b_rd_last  = (b_rd_idx_ff == b_last_idx);
  wire       b_wr_last  = (b_wr_idx_ff == b_last_idx);

  wire a_fifo_wr = a_sel & ~a_dir & ~a_mail & porta_input_ready;                  // R13
  wire a_fifo_rd = a_sel &  a_dir & ~a_mail & (b2a_cnt_a != `BFM_PTR_ZERO);       // R20
  wire a_mail_wr = a_sel & ~a_dir &  a_mail & a2b_mail_full_n_ff;
  wire a_mail_rd = a_sel &  a_dir &  a_mail;
  wire b_fifo_rd = b_sel &  b_dir & ~b_mail & (a2b_cnt_b != `BFM_PTR_ZERO);       // R14
  wire b_fifo_wr = b_sel & ~b_dir & ~b_mail & portb_input_ready;                  // R15
  wire b_mail_wr = b_sel & ~b_dir &  b_mail & b2a_mail_full_n_ff;
  wire b_mail_rd = b_sel &  b_dir &  b_mail;

  // ----------------------------------------------------------------------
  // pointer updates and cross views
  // ----------------------------------------------------------------------
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      a2b_wptr_ff    <= `BFM_PTR_ZERO;
      a2b_rptr_ff    <= `BFM_PTR_ZERO;
      b2a_wptr_ff    <= `BFM_PTR_ZERO;
      b2a_rptr_ff    <= `BFM_PTR_ZERO;
      a2b_r_s1_ff    <= `BFM_PTR_ZERO;
      a2b_rview_a_ff <= `BFM_PTR_ZERO;
      b2a_w_s1_ff    <= `BFM_PTR_ZERO;
      b2a_wview_a_ff <= `BFM_PTR_ZERO;
      a2b_w_s1_ff    <= `BFM_PTR_ZERO;
      a2b_wview_b_ff <= `BFM_PTR_ZERO;
      b2a_r_s1_ff    <= `BFM_PTR_ZERO;
      b2a_rview_b_ff <= `BFM_PTR_ZERO;
      b_rd_idx_ff    <= `BFM_IDX_ZERO;
      b_wr_idx_ff    <= `BFM_IDX_ZERO;
    end else begin
      if (a_fifo_wr) begin
        a2b_wptr_ff <= a2b_wptr_ff + `BFM_PTR_ONE;
      end
      if (a_fifo_rd) begin
        b2a_rptr_ff <= b2a_rptr_ff + `BFM_PTR_ONE;
      end
      if (b_fifo_rd) begin
        b_rd_idx_ff <= b_rd_last ? `BFM_IDX_ZERO : (b_rd_idx_ff + `BFM_IDX_ONE);
        if (b_rd_last) begin
          a2b_rptr_ff <= a2b_rptr_ff + `BFM_PTR_ONE;                              // R3 R8
        end
      end
      if (b_fifo_wr) begin
        b_wr_idx_ff <= b_wr_last ? `BFM_IDX_ZERO : (b_wr_idx_ff + `BFM_IDX_ONE);
        if (b_wr_last) begin
          b2a_wptr_ff <= b2a_wptr_ff + `BFM_PTR_ONE;                              // R5 R6 R11
        end
      end
      a2b_r_s1_ff <= a2b_rptr_ff;
      b2a_w_s1_ff <= b2a_wptr_ff;
      a2b_w_s1_ff <= a2b_wptr_ff;
      b2a_r_s1_ff <= b2a_rptr_ff;
      if (a_edge) begin
        a2b_rview_a_ff <= a2b_r_s1_ff;                                            // R22 R1 R2 R10
        b2a_wview_a_ff <= b2a_w_s1_ff;                                            // R9
      end
      if (b_edge) begin
        a2b_wview_b_ff <= a2b_w_s1_ff;                                            // R22 R7
        b2a_rview_b_ff <= b2a_r_s1_ff;                                            // R4 R6
      end
    end
  end

  // ----------------------------------------------------------------------
  // queue storage and port b bus matching
  // ----------------------------------------------------------------------
  reg  [35:0] a2b_mem [0:255];
  reg  [35:0] b2a_mem [0:255];
  reg  [35:0] b2a_asm_ff;
  reg  [35:0] b_wr_word;
  reg  [35:0] b_rd_piece;
  wire [35:0] a2b_head = a2b_mem[a2b_rptr_ff[7:0]];
  wire [35:0] b2a_head = b2a_mem[b2a_rptr_ff[7:0]];

  always @* begin
    b_wr_word = b2a_asm_ff;
    case (b_size)
      `BFM_SIZE_WORD: b_wr_word[b_wr_slot[0]*`BFM_WORD_W +: `BFM_WORD_W] = b_data[17:0];
      `BFM_SIZE_BYTE: b_wr_word[b_wr_slot*`BFM_BYTE_W +: `BFM_BYTE_W] = b_data[8:0];
      default:        b_wr_word = b_data;
    endcase
  end

  always @* begin
    b_rd_piece = 36'h000000000;
    case (b_size)
      `BFM_SIZE_WORD: b_rd_piece[17:0] = a2b_head[b_rd_slot[0]*`BFM_WORD_W +: `BFM_WORD_W];
      `BFM_SIZE_BYTE: b_rd_piece[8:0] = a2b_head[b_rd_slot*`BFM_BYTE_W +: `BFM_BYTE_W];
      default:        b_rd_piece = a2b_head;
    endcase
  end

  always @(posedge mclk) begin
    if (a_fifo_wr) begin
      a2b_mem[a2b_wptr_ff[7:0]] <= a_data;
    end
    if (b_fifo_wr && b_wr_last) begin
      b2a_mem[b2a_wptr_ff[7:0]] <= b_wr_word;
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      b2a_asm_ff <= 36'h000000000;
    end else if (b_fifo_wr && !b_wr_last) begin
      b2a_asm_ff <= b_wr_word;
    end
  end

  // ----------------------------------------------------------------------
  // mailboxes
  // ----------------------------------------------------------------------
  reg  [35:0] a2b_mailbox_ff;
  reg  [35:0] b2a_mailbox_ff;
  reg         a2b_clr_pend_ff;
  reg         b2a_clr_pend_ff;

  function [35:0] bfm_size_mask;
    input [1:0]  size;
    input [35:0] d;
    begin
      case (size)
        `BFM_SIZE_WORD: bfm_size_mask = {18'h00000, d[17:0]};
        `BFM_SIZE_BYTE: bfm_size_mask = {27'h0000000, d[8:0]};
        default:        bfm_size_mask = d;
      endcase
    end
  endfunction

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      a2b_mailbox_ff     <= 36'h000000000;
      b2a_mailbox_ff     <= 36'h000000000;
      a2b_mail_full_n_ff <= 1'b1;
      b2a_mail_full_n_ff <= 1'b1;
      a2b_clr_pend_ff    <= 1'b0;
      b2a_clr_pend_ff    <= 1'b0;
    end else begin
      if (a_mail_wr) begin
        a2b_mailbox_ff <= bfm_size_mask(b_size, a_data);                          // R16 R17
      end
      if (b_mail_wr) begin
        b2a_mailbox_ff <= bfm_size_mask(b_size, b_data);                          // R18 R19
      end
      // far-side reads are held until the owning port edge takes them
      if (b_mail_rd) begin
        a2b_clr_pend_ff <= 1'b1;                                                  // R22
      end else if (a_edge) begin
        a2b_clr_pend_ff <= 1'b0;
      end
      if (a_mail_rd) begin
        b2a_clr_pend_ff <= 1'b1;                                                  // R22
      end else if (b_edge) begin
        b2a_clr_pend_ff <= 1'b0;
      end
      // a new write wins over a pending release
      if (a_mail_wr) begin
        a2b_mail_full_n_ff <= 1'b0;                                               // R21
      end else if (a_edge && a2b_clr_pend_ff) begin
        a2b_mail_full_n_ff <= 1'b1;                                               // R21
      end
      if (b_mail_wr) begin
        b2a_mail_full_n_ff <= 1'b0;                                               // R21
      end else if (b_edge && b2a_clr_pend_ff) begin
        b2a_mail_full_n_ff <= 1'b1;                                               // R21
      end
    end
  end

  assign a2b_mail_full_n = a2b_mail_full_n_ff;
  assign b2a_mail_full_n = b2a_mail_full_n_ff;

  // ----------------------------------------------------------------------
  // output data and drive enables
  // ----------------------------------------------------------------------
  reg  [35:0] porta_data_ff;
  reg  [35:0] portb_data_ff;
  reg         porta_oe_n_ff;
  reg         portb_oe_n_ff;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      porta_data_ff <= 36'h000000000;
      portb_data_ff <= 36'h000000000;
      porta_oe_n_ff <= 1'b1;
      portb_oe_n_ff <= 1'b1;
    end else begin
      if (a_fifo_rd) begin
        porta_data_ff <= b2a_head;
      end else if (a_mail_rd) begin
        porta_data_ff <= b2a_mailbox_ff;                                          // R18 R19
      end
      if (b_fifo_rd) begin
        portb_data_ff <= b_rd_piece;
      end else if (b_mail_rd) begin
        portb_data_ff <= a2b_mailbox_ff;                                          // R16 R17
      end
      porta_oe_n_ff <= ~(~a_prev_ff[`BFM_V_SEL_N] & a_dir);
      portb_oe_n_ff <= ~(~b_prev_ff[`BFM_V_SEL_N] & b_dir);
    end
  end

  assign porta_data_out  = porta_data_ff;
  assign portb_data_out  = portb_data_ff;
  assign porta_data_oe_n = porta_oe_n_ff;
  assign portb_data_oe_n = portb_oe_n_ff;

endmodule

`default_nettype wire

// File: rtl/bfm_defines.vh
// bfm_defines.vh: constants for the bidirectional fifo with mailboxes
// assumes: included by bare name from every rtl file of this block
`ifndef BFM_DEFINES_VH
`define BFM_DEFINES_VH

// ----------------------------------------------------------------------
// widths and depth
// ----------------------------------------------------------------------
`define BFM_DATA_W        36
`define BFM_WORD_W        18
`define BFM_BYTE_W        9
`define BFM_ADDR_W        8
`define BFM_PTR_W         9
`define BFM_DEPTH         9'h100
`define BFM_PTR_ONE       9'h001
`define BFM_PTR_ZERO      9'h000

// ----------------------------------------------------------------------
// partial flag offsets
// ----------------------------------------------------------------------
`define BFM_AE_OFFSET     9'h008
`define BFM_AF_OFFSET     9'h008

// ----------------------------------------------------------------------
// port b bus size codes and last piece index
// ----------------------------------------------------------------------
`define BFM_SIZE_LONG     2'h0
`define BFM_SIZE_WORD     2'h1
`define BFM_SIZE_BYTE     2'h2
`define BFM_IDX_ZERO      2'h0
`define BFM_IDX_ONE       2'h1
`define BFM_LAST_WORD     2'h1
`define BFM_LAST_BYTE     2'h3

// ----------------------------------------------------------------------
// layout of the sampled pin vectors
// ----------------------------------------------------------------------
`define BFM_PA_W          41
`define BFM_PB_W          44
`define BFM_V_CLK         40
`define BFM_V_SEL_N       39
`define BFM_V_DIR         38
`define BFM_V_MAIL        37
`define BFM_V_EN          36
`define BFM_V_SIZE_HI     42
`define BFM_V_SIZE_LO     41
`define BFM_V_BIG         43

`endif

// File: rtl/bfm_sync2.v
// bfm_sync2.v: two flip-flop synchroniser for a group of pins
// assumes: inputs are asynchronous to mclk; each bit is used on its own
`include "bfm_defines.vh"
`default_nettype none

module bfm_sync2 #(
  parameter W = 1
) (
  // clock and reset
  input  wire         mclk,
  input  wire         nrst,
  // pins in, sampled copy out
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;

endmodule

`default_nettype wire

// File: verification/bfm_bidir_fifo_props.sv
// bfm_bidir_fifo_props.sv: flag and mailbox checks on the fifo ports
// assumes: bound to bfm_bidir_fifo; port clocks far slower than mclk
`default_nettype none
module bfm_bidir_fifo_props (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // port pins
  input wire logic port_a_clock,
  input wire logic porta_select_n,
  input wire logic porta_dir,
  input wire logic porta_mail_sel,
  input wire logic porta_enable,
  input wire logic port_b_clock,
  input wire logic portb_select_n,
  input wire logic portb_dir,
  input wire logic portb_mail_sel,
  input wire logic portb_enable,
  // flags
  input wire logic porta_full_n,
  input wire logic porta_input_ready,
  input wire logic porta_almost_full_n,
  input wire logic porta_almost_empty_n,
  input wire logic a2b_mail_full_n,
  input wire logic portb_full_n,
  input wire logic portb_input_ready,
  input wire logic portb_almost_empty_n,
  input wire logic b2a_mail_full_n
);
  timeunit 1ns / 100ps;
  // ----------------------------------------------------------------
  // ages in mclk of the latest port edge of each kind
  // ----------------------------------------------------------------
  logic [1:0] clk_ff;
  logic [7:0] age_ff [8];
  logic [7:0] ev;
  wire a_r = port_a_clock & ~clk_ff[0];
  wire b_r = port_b_clock & ~clk_ff[1];
  wire a_go = a_r & ~porta_select_n & porta_enable;
  wire b_go = b_r & ~portb_select_n & portb_enable;
  always_comb begin
    ev[0] = a_r;
    ev[1] = a_go & ~porta_dir & ~porta_mail_sel;
    ev[2] = a_go & porta_dir & ~porta_mail_sel;
    ev[3] = a_go & ~porta_dir & porta_mail_sel;
    ev[4] = b_r;
    ev[5] = b_go & ~portb_dir & ~portb_mail_sel;
    ev[6] = b_go & portb_dir & ~portb_mail_sel;
    ev[7] = b_go & portb_dir & portb_mail_sel;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    clk_ff <= nrst ? {port_b_clock, port_a_clock} : 2'h0;
    for (int i = 0; i < 8; i++) begin
      if (!nrst || (!ev[i] && age_ff[i] == 8'hff)) age_ff[i] <= 8'hff;
      else age_ff[i] <= ev[i] ? 8'h00 : age_ff[i] + 8'h01;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_ready_pair_a:
    assert property (porta_input_ready == porta_full_n) else $error("port a ready differs");
  a_ready_pair_b:
    assert property (portb_input_ready == portb_full_n) else $error("port b ready differs");
  a_fulla_far_read:
    assert property ($rose(porta_full_n) |-> age_ff[6] <= 8'd60) else $error("a full late");
  a_fulla_own_edge:
    assert property ($rose(porta_full_n) |-> age_ff[0] <= 8'd8) else $error("a full off edge");
  a_fullb_far_read:
    assert property ($rose(portb_full_n) |-> age_ff[2] <= 8'd60) else $error("b full late");
  a_aeb_far_write:
    assert property ($rose(portb_almost_empty_n) |-> age_ff[1] <= 8'd60) else $error("aeb late");
  a_aea_far_write:
    assert property ($rose(porta_almost_empty_n) |-> age_ff[5] <= 8'd60) else $error("aea late");
  a_afa_far_read:
    assert property ($rose(porta_almost_full_n) |-> age_ff[6] <= 8'd60) else $error("afa late");
  a_mail_set_own:
    assert property ($fell(a2b_mail_full_n) |-> age_ff[3] <= 8'd8) else $error("mail set odd");
  a_mail_clear_far:
    assert property ($rose(a2b_mail_full_n) |-> age_ff[7] <= 8'd60) else $error("mail clr odd");
  c_full_a: cover property ($fell(porta_full_n));
  c_aeb_up: cover property ($rose(portb_almost_empty_n));
  c_mail_b: cover property ($rose(b2a_mail_full_n));
endmodule
`default_nettype wire

// File: verification/bfm_port_model.sv
// bfm_port_model.sv: free-running port clock and bus cycles of one port
// assumes: the bench calls acc once per port cycle, idle after the last
`default_nettype none
module bfm_port_model #(
  parameter real PHASE = 0.0
) (
  // port clock and pins
  output var logic        clk,
  output var logic        sel_n,
  output var logic        dir,
  output var logic        mail,
  output var logic        en,
  output var logic [35:0] dout
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    clk = 0;
    sel_n = 1;
    dir = 0;
    mail = 0;
    en = 0;
    dout = '0;
    #(PHASE);
    forever #62.5 clk = ~clk;
  end
  // pins set after a rise, taken at the next rise
  task automatic acc(input logic d, input logic m, input logic [35:0] v);
    @(posedge clk);
    #12;
    sel_n = 0;
    dir = d;
    mail = m;
    en = 1;
    dout = d ? ~dout : v;
  endtask
  // released data line shows the inverse of its last value
  task automatic idle;
    @(posedge clk);
    #12;
    sel_n = 1;
    en = 0;
    dout = ~dout;
  endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// tb_top.sv: self-checking bench for the bidirectional fifo
// assumes: bfm_defines.vh on the include path of the rtl
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, nrst, port_a_clock, porta_select_n, porta_dir, porta_mail_sel;
  logic        porta_enable, port_b_clock, portb_select_n, portb_dir, portb_mail_sel;
  logic        portb_enable, portb_big_endian, porta_data_oe_n, portb_data_oe_n;
  logic        porta_full_n, porta_input_ready, porta_almost_full_n, porta_almost_empty_n;
  logic        portb_full_n, portb_input_ready, portb_almost_full_n, portb_almost_empty_n;
  logic        a2b_mail_full_n, b2a_mail_full_n;
  logic [1:0]  portb_size;
  logic [35:0] pa_dout, pb_dout, porta_data_in, portb_data_in, porta_data_out, portb_data_out;
  logic [35:0] qa[$], qb[$];
  int          n_tests, miscompares, sz, np;
  assign porta_data_in = porta_data_oe_n ? pa_dout : porta_data_out;
  assign portb_data_in = portb_data_oe_n ? pb_dout : portb_data_out;
  bfm_bidir_fifo uut (.mclk, .nrst, .port_a_clock, .porta_select_n, .porta_dir,
    .porta_mail_sel, .porta_enable, .porta_data_in, .porta_data_out, .porta_data_oe_n,
    .porta_full_n, .porta_input_ready, .porta_almost_full_n, .porta_almost_empty_n,
    .a2b_mail_full_n, .port_b_clock, .portb_select_n, .portb_dir, .portb_mail_sel,
    .portb_enable, .portb_size, .portb_big_endian, .portb_data_in, .portb_data_out,
    .portb_data_oe_n, .portb_full_n, .portb_input_ready, .portb_almost_full_n,
    .portb_almost_empty_n, .b2a_mail_full_n);
  bfm_port_model #(.PHASE(0.0)) pa (.clk(port_a_clock), .sel_n(porta_select_n),
    .dir(porta_dir), .mail(porta_mail_sel), .en(porta_enable), .dout(pa_dout));
  bfm_port_model #(.PHASE(40.3)) pb (.clk(port_b_clock), .sel_n(portb_select_n),
    .dir(portb_dir), .mail(portb_mail_sel), .en(portb_enable), .dout(pb_dout));
  initial begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic rst(input int s);
    nrst = 0;
    sz = s;
    np = 1 << s;
    portb_size = 2'(s);
    portb_big_endian = 1'(s);
    qa.delete();
    qb.delete();
    repeat (5) @(posedge mclk);
    @(posedge port_a_clock);
    #12 nrst = 1;
  endtask
  function automatic logic [35:0] mk();
    logic [35:0] v;
    v = {4'($urandom()), $urandom()};
    for (int i = 0; i < 4; i++) v[9*i +: 3] = 3'(i);
    return v;
  endfunction
  function automatic logic [35:0] msk();
    return (36'h1 << (36 / np)) - 36'h1;
  endfunction
  task automatic settle;
    repeat (3) @(posedge port_a_clock);
    repeat (3) @(posedge port_b_clock);
  endtask
  task automatic wr_a(input int n);
    logic [35:0] v;
    repeat (n) begin
      v = mk();
      for (int i = 0; i < np; i++) qb.push_back((v >> (36 / np * (i ^ np / 2 % 2))) & msk());
      pa.acc(0, 0, v);
    end
    pa.idle;
  endtask
  task automatic wr_b(input int n);
    logic [35:0] v;
    repeat (n) begin
      v = mk();
      if (sz == 0) qa.push_back(v);
      pb.acc(0, 0, v);
    end
    pb.idle;
  endtask
  task automatic rd_b(input int n);
    repeat (n) pb.acc(1, 0, '0);
    pb.idle;
  endtask
  task automatic rd_a(input int n);
    repeat (n) pa.acc(1, 0, '0);
    pa.idle;
  endtask
  // ----------------------------------------------------------------
  // result watchers
  // ----------------------------------------------------------------
  initial forever begin
    @(portb_data_out);
    if (nrst) chk(portb_data_out, qb.size() ? qb.pop_front() : 36'hx);
  end
  initial forever begin
    @(porta_data_out);
    if (nrst) chk(porta_data_out, qa.size() ? qa.pop_front() : 36'hx);
  end
  initial begin
    #400000;
    miscompares++;
    wrap_up;
  end
  initial begin
    logic [35:0] v;
    nrst = 0;
    portb_size = 2'h0;
    n_tests = 0;
    miscompares = 0;
    void'($urandom(32'he3a8));
    for (int s = 0; s < 3; s++) begin
      rst(s);
      wr_a(9);
      rd_b(np - 1);
      settle;
      chk(portb_almost_empty_n, 1'b1);
      rd_b(1);
      settle;
      chk(portb_almost_empty_n, 1'b0);
      rd_b(8 * np);
      wr_b(9 * np - 1);
      settle;
      chk(porta_almost_empty_n, 1'b0);
      wr_b(1);
      settle;
      chk(porta_almost_empty_n, 1'b1);
      v = mk();
      v[2:0] = 3'h5;
      qa.delete();
      qb.push_back(v & msk());
      pa.acc(0, 1, v);
      pa.idle;
      settle;
      chk(a2b_mail_full_n, 1'b0);
      rd_b(0);
      pb.acc(1, 1, '0);
      pb.idle;
      settle;
      chk(a2b_mail_full_n, 1'b1);
      qa.push_back(~v & msk());
      pb.acc(0, 1, ~v);
      pb.idle;
      settle;
      chk(b2a_mail_full_n, 1'b0);
      pa.acc(1, 1, '0);
      pa.idle;
      settle;
      chk(b2a_mail_full_n, 1'b1);
      chk(36'(qa.size() + qb.size()), 36'h0);
      $display("size test %0d done", s);
    end
    rst(0);
    wr_a(247);
    settle;
    chk(porta_almost_full_n, 1'b1);
    wr_a(1);
    settle;
    chk(porta_almost_full_n, 1'b0);
    wr_a(7);
    settle;
    chk(porta_full_n, 1'b1);
    wr_a(1);
    pa.acc(0, 0, mk());
    pa.idle;
    settle;
    chk(porta_full_n, 1'b0);
    chk(porta_input_ready, 1'b0);
    rd_b(1);
    settle;
    chk(porta_input_ready, 1'b1);
    chk(porta_almost_full_n, 1'b0);
    rd_b(8);
    settle;
    chk(porta_almost_full_n, 1'b1);
    rd_b(247);
    settle;
    chk(36'(qb.size()), 36'h0);
    $display("a to b fill test done");
    wr_b(255);
    settle;
    chk(portb_input_ready, 1'b1);
    chk(portb_almost_full_n, 1'b0);
    wr_b(1);
    settle;
    chk(portb_full_n, 1'b0);
    rd_a(1);
    settle;
    chk(portb_full_n, 1'b1);
    rd_a(8);
    settle;
    chk(portb_almost_full_n, 1'b1);
    rd_a(247);
    settle;
    chk(36'(qa.size()), 36'h0);
    $display("b to a fill test done");
    wrap_up;
  end
endmodule
bind bfm_bidir_fifo bfm_bidir_fifo_props u_props (.mclk, .nrst, .port_a_clock,
  .porta_select_n, .porta_dir, .porta_mail_sel, .porta_enable, .port_b_clock,
  .portb_select_n, .portb_dir, .portb_mail_sel, .portb_enable, .porta_full_n,
  .porta_input_ready, .porta_almost_full_n, .porta_almost_empty_n, .a2b_mail_full_n,
  .portb_full_n, .portb_input_ready, .portb_almost_empty_n, .b2a_mail_full_n);
`default_nettype wire
